// ==== hw/npc_controller.sv ====
// page program controller: command sequencer, page buffer, protection
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module npc_controller
  import npc_pkg::*;
#(
  parameter int unsigned AW           = 16,
  parameter int unsigned PAGE_BYTES   = 64,
  parameter int unsigned SHORT_CYC    = SHORT_OP_CYC,
  parameter int unsigned LONG_CYC     = LONG_OP_CYC,
  parameter logic [AW-1:0] NVDATA_BASE = 16'h1400,
  parameter logic [AW-1:0] NVDATA_TOP  = 16'h147f,
  parameter logic [AW-1:0] USER_BASE   = 16'h1300,
  parameter logic [AW-1:0] USER_TOP    = 16'h131f,
  parameter logic [AW-1:0] FLASH_BASE  = 16'h8000
)(
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  input  wire logic             debug_programming_port,
  // memory bus from cpu
  input  wire logic [AW-1:0]    mem_addr,
  input  wire logic [7:0]       mem_wdata,
  input  wire logic             mem_wr,
  input  wire logic             mem_rd,
  input  wire logic [AW-1:0]    exec_addr,
  input  wire logic             wake,
  output logic                  mem_wait,
  output logic                  cpu_halt,
  output logic                  loader_hidden,
  // fuses
  input  wire logic [7:0]       loader_end_fuse,
  input  wire logic [7:0]       program_region_end_fuse,
  input  wire logic             keep_nvdata_fuse,
  // array side
  output logic                  arr_erase,
  output logic                  arr_write,
  output logic                  arr_chip_erase,
  output logic                  arr_nvdata_erase,
  output logic                  arr_keep_nvdata,
  output logic                  arr_is_nvdata,
  output logic [AW-1:0]         arr_page_addr,
  output logic [8*PAGE_BYTES-1:0] arr_data,
  output logic [PAGE_BYTES-1:0] arr_mask,
  output logic                  fuse_write,
  output logic [15:0]           fuse_addr,
  output logic [15:0]           fuse_data
);
  localparam int unsigned PW = $clog2(PAGE_BYTES);
  localparam int unsigned CW = $clog2(LONG_CYC + 1);

  // ***********************************************************
  // decode
  // ***********************************************************
  npc_region_type exec_rgn;
  npc_region_type tgt_rgn;
  npc_state_type  state;
  npc_op_type     op;
  logic [7:0]           guard_cnt;
  logic [1:0]           locks;
  logic                 err;
  logic [7:0]           page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] marked;
  logic [AW-1:0]        page_addr;
  logic                 tgt_nvdata;
  logic [CW-1:0]        cnt;
  logic [15:0]          data_reg;
  logic                 busy;
  logic                 flash_hit;
  logic                 nv_hit;
  logic                 user_hit;
  logic                 store_ok;
  logic                 cmd_wr;
  logic                 cmd_ok;
  logic                 next_err;
  npc_op_type           wr_op;

  npc_region_map #(.AW(AW)) u_exec_map (
    .addr                    (exec_addr),
    .loader_end_fuse         (loader_end_fuse),
    .program_region_end_fuse (program_region_end_fuse),
    .region                  (exec_rgn)
  );
  npc_region_map #(.AW(AW)) u_tgt_map (
    .addr                    (page_addr - FLASH_BASE),
    .loader_end_fuse         (loader_end_fuse),
    .program_region_end_fuse (program_region_end_fuse),
    .region                  (tgt_rgn)
  );

  assign busy      = (state != ST_IDLE);
  assign nv_hit    = (mem_addr >= NVDATA_BASE) && (mem_addr <= NVDATA_TOP);
  assign user_hit  = (mem_addr >= USER_BASE) && (mem_addr <= USER_TOP);
  assign flash_hit = (mem_addr >= FLASH_BASE);
  assign wr_op     = npc_op_type'(reg_wdata[2:0]);
  assign cmd_wr    = reg_wr && (reg_addr == REG_CONTROL_A);

  // stores from storage-region code refused; debug port may always load
  assign store_ok = debug_programming_port || (exec_rgn != RGN_STORAGE); // RULE_03

  // command legality checked at issue time
  always_comb
  begin
    cmd_ok = 1'b1;
    if (!debug_programming_port)
    begin
      if (wr_op == FUSE_PROGRAM_OP)
        cmd_ok = 1'b0; // RULE_20
      if (wr_op == OP_PAGE_PROGRAM || wr_op == PAGE_WIPE_OP || wr_op == PAGE_WIPE_AND_PROGRAM_OP)
      begin
        if (exec_rgn == RGN_STORAGE)
          cmd_ok = 1'b0; // RULE_03
        else if (!tgt_nvdata)
        begin
          if (tgt_rgn == RGN_LOADER)
            cmd_ok = 1'b0; // RULE_04
          else if (tgt_rgn == RGN_PROGRAM && (exec_rgn != RGN_LOADER || locks[LOCK_WRITE_BIT]))
            cmd_ok = 1'b0; // RULE_03 RULE_05
        end
      end
      if ((wr_op == FULL_WIPE_OP || wr_op == NVDATA_WIPE_OP) && exec_rgn == RGN_STORAGE)
        cmd_ok = 1'b0; // RULE_03
    end
  end

  // ***********************************************************
  // unlock window
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      guard_cnt <= 8'h00;
    else if (reg_wr && reg_addr == REG_GUARD && reg_wdata == SELFPROG_UNLOCK_KEY)
      guard_cnt <= 8'(UNLOCK_WINDOW); // RULE_23
    else if (cmd_wr)
      guard_cnt <= 8'h00;
    else if (guard_cnt != 8'h00)
      guard_cnt <= guard_cnt - 8'h01;
  end

  // ***********************************************************
  // lock bits
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      locks <= 2'b00;
    else if (reg_wr && reg_addr == REG_CONTROL_B)
    begin
      if (reg_wdata[LOCK_WRITE_BIT])
        locks[LOCK_WRITE_BIT] <= 1'b1; // RULE_05
      if (reg_wdata[LOCK_READ_BIT] && exec_rgn == RGN_LOADER)
        locks[LOCK_READ_BIT] <= 1'b1; // RULE_05
    end
  end
  assign loader_hidden = locks[LOCK_READ_BIT] && exec_rgn != RGN_LOADER; // RULE_05

  // ***********************************************************
  // address and data registers
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      page_addr  <= '0;
      tgt_nvdata <= 1'b0;
      data_reg   <= 16'h0000;
    end
    else
    begin
      if (mem_wr && !busy && store_ok && (flash_hit || nv_hit || user_hit))
      begin
        page_addr  <= mem_addr & ~AW'(PAGE_BYTES - 1);
        tgt_nvdata <= nv_hit || user_hit; // RULE_07
      end
      else if (reg_wr && reg_addr == REG_ADDR_LO)
        page_addr[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == REG_ADDR_HI)
        page_addr[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == REG_DATA_LO)
        data_reg[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == REG_DATA_HI)
        data_reg[15:8] <= reg_wdata;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE; // RULE_22
      op    <= OP_NONE;
      cnt   <= '0;
      err   <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (cmd_wr && (guard_cnt != 8'h00 || debug_programming_port)) // RULE_13 RULE_25
          begin
            op  <= wr_op; // RULE_24
            err <= !cmd_ok;
            if (!cmd_ok || wr_op == OP_NONE)
              state <= ST_IDLE;
            else if (wr_op == PAGE_WIPE_OP && marked == '0)
              state <= ST_IDLE; // RULE_15
            else
            begin
              unique case (wr_op)
                OP_PAGE_PROGRAM:          cnt <= CW'(SHORT_CYC);
                PAGE_WIPE_OP:             cnt <= CW'(SHORT_CYC);
                PAGE_WIPE_AND_PROGRAM_OP: cnt <= CW'(SHORT_CYC); // RULE_21
                BUFFER_RESET_OP:          cnt <= CW'(CLEAR_OP_CYC); // RULE_17
                FUSE_PROGRAM_OP:          cnt <= CW'(SHORT_CYC);
                default:                  cnt <= CW'(LONG_CYC); // RULE_21
              endcase
              state <= (wr_op == PAGE_WIPE_OP || wr_op == PAGE_WIPE_AND_PROGRAM_OP) ? ST_ERASE :
                       (wr_op == OP_PAGE_PROGRAM) ? ST_WRITE : ST_WAIT;
            end
          end
        end
        ST_ERASE:
        begin
          if (cnt <= CW'(1))
          begin
            // erase-write keeps the buffer and goes on to write
            if (op == PAGE_WIPE_AND_PROGRAM_OP)
            begin
              state <= ST_WRITE; // RULE_16
              cnt   <= CW'(SHORT_CYC);
            end
            else
              state <= ST_IDLE;
          end
          else
            cnt <= cnt - CW'(1);
        end
        ST_WRITE, ST_WAIT:
        begin
          if (cnt <= CW'(1))
            state <= ST_IDLE;
          else
            cnt <= cnt - CW'(1);
        end
      endcase
    end
  end

  // array strobes pulse in the first cycle of each phase
  logic [3:0] prev_state;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      prev_state <= ST_IDLE;
    else
      prev_state <= state;
  end
  assign arr_erase        = state == ST_ERASE && prev_state != ST_ERASE;
  assign arr_write        = state == ST_WRITE && prev_state != ST_WRITE; // RULE_14
  assign arr_chip_erase   = state == ST_WAIT && prev_state == ST_IDLE && op == FULL_WIPE_OP; // RULE_18
  assign arr_keep_nvdata  = keep_nvdata_fuse; // RULE_18 RULE_07
  assign arr_nvdata_erase = state == ST_WAIT && prev_state == ST_IDLE && op == NVDATA_WIPE_OP; // RULE_19
  assign fuse_write       = state == ST_WAIT && prev_state == ST_IDLE && op == FUSE_PROGRAM_OP; // RULE_20
  assign fuse_addr        = page_addr;
  assign fuse_data        = data_reg;
  assign arr_is_nvdata    = tgt_nvdata;
  assign arr_page_addr    = page_addr;
  assign arr_mask         = tgt_nvdata ? marked : {PAGE_BYTES{1'b1}}; // RULE_06

  // halt cpu for flash ops, clear, chip and eeprom erase, fuse write
  assign cpu_halt = busy && !((op == OP_PAGE_PROGRAM || op == PAGE_WIPE_OP ||
                    op == PAGE_WIPE_AND_PROGRAM_OP) && tgt_nvdata); // RULE_14 RULE_15 RULE_16 RULE_17 RULE_19
  assign mem_wait = busy && mem_rd && (flash_hit || nv_hit || user_hit); // RULE_08

  // ***********************************************************
  // page buffer
  // ***********************************************************
  logic buf_clear;
  assign buf_clear = wake || (busy && cnt <= CW'(1) && !(state == ST_ERASE && op == PAGE_WIPE_AND_PROGRAM_OP)
                     && op != FULL_WIPE_OP && op != NVDATA_WIPE_OP && op != FUSE_PROGRAM_OP); // RULE_11 RULE_16

  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++)
    begin : g_buf
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          page_buf[gi] <= 8'hff; // RULE_11
          marked[gi]   <= 1'b0;
        end
        else if (buf_clear)
        begin
          page_buf[gi] <= 8'hff; // RULE_11
          marked[gi]   <= 1'b0;
        end
        else if (mem_wr && !busy && store_ok && (flash_hit || nv_hit || user_hit)
                 && mem_addr[PW-1:0] == PW'(gi)) // RULE_09
        begin
          page_buf[gi] <= page_buf[gi] & mem_wdata; // RULE_10
          marked[gi]   <= 1'b1; // RULE_06
        end
      end
      assign arr_data[8*gi +: 8] = page_buf[gi];
    end
  endgenerate

  // ***********************************************************
  // register read
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CONTROL_A: reg_rdata <= {5'h00, op};
        REG_CONTROL_B: reg_rdata <= {6'h00, locks};
        REG_STATUS:    reg_rdata <= {5'h00, err, busy && tgt_nvdata, busy && !tgt_nvdata};
        REG_DATA_LO:   reg_rdata <= data_reg[7:0];
        REG_DATA_HI:   reg_rdata <= data_reg[15:8];
        REG_ADDR_LO:   reg_rdata <= page_addr[7:0];
        REG_ADDR_HI:   reg_rdata <= page_addr[15:8];
        default:       reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : npc_controller
`default_nettype wire

// ==== hw/npc_pkg.sv ====
// constants and types for the page program controller
// Behaviour
// RULE_01: flash split into loader, program, storage regions in 256-byte blocks by fuses.
// RULE_02: a zero end fuse gives whole flash to its region; both zero means loader.
// RULE_03: loader code writes program and storage; program code writes storage; storage none.
// RULE_04: cpu writes never modify the loader region.
// RULE_05: write lock and read lock hold until reset; read lock hides loader reads.
// RULE_06: eeprom erase and write touch only bytes marked in the page buffer.
// RULE_07: user page survives chip erase, programs like eeprom, debug port may write it.
// RULE_08: array reads during write or erase stall the bus until done.
// RULE_09: one shared page buffer loaded by stores, low address bits pick position.
// RULE_10: each buffer store leaves AND of new and old content.
// RULE_11: buffer set to all ones on reset, page op, buffer clear, wake.
// RULE_12: software erases a flash page before programming it.
// RULE_13: software writes unlock key then the op code within four instructions.
// RULE_14: page write copies buffer then clears it; cpu stalls only for flash.
// RULE_15: page erase needs a marked byte; flash whole page halts, eeprom marked bytes.
// RULE_16: erase-write erases then writes without clearing between, clears after.
// RULE_17: buffer clear sets all ones and halts cpu for seven cycles.
// RULE_18: chip erase sets flash ones, eeprom ones unless keep fuse set.
// RULE_19: eeprom erase sets all eeprom ones, cpu halted until done.
// RULE_20: only debug port starts fuse write, from address and data; effect after reset.
// RULE_21: page write and erase take 2ms; erase-write, chip and eeprom erase 4ms.
// RULE_22: reset during a write aborts it.
// RULE_23: unlock key is 0x9D; other values leave commands locked.
// RULE_24: op codes 0 none,1 write,2 erase,3 erase-write,4 clear,5 chip,6 eeprom,7 fuse.
// RULE_25: command write without unlock is accepted but leaves the register unchanged.
package npc_pkg;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SHORT_OP_MS     = 2;
  localparam int unsigned LONG_OP_MS      = 4;
  localparam int unsigned SHORT_OP_CYC    = CLK_HZ / 1000 * SHORT_OP_MS;
  localparam int unsigned LONG_OP_CYC     = CLK_HZ / 1000 * LONG_OP_MS;
  localparam int unsigned CLEAR_OP_CYC    = 7;
  localparam int unsigned UNLOCK_WINDOW   = 4;
  localparam int unsigned BLOCK_SHIFT     = 8;
  // ***********************************************************
  // register offsets and fields
  // ***********************************************************
  localparam logic [3:0] REG_CONTROL_A    = 4'h0;
  localparam logic [3:0] REG_CONTROL_B    = 4'h1;
  localparam logic [3:0] REG_STATUS       = 4'h2;
  localparam logic [3:0] REG_DATA_LO      = 4'h6;
  localparam logic [3:0] REG_DATA_HI      = 4'h7;
  localparam logic [3:0] REG_ADDR_LO      = 4'h8;
  localparam logic [3:0] REG_ADDR_HI      = 4'h9;
  localparam logic [3:0] REG_GUARD        = 4'hf;
  localparam logic [7:0] SELFPROG_UNLOCK_KEY = 8'h9d;
  localparam logic [7:0] FUSE_ZERO        = 8'h00;
  localparam int unsigned LOCK_WRITE_BIT  = 0;
  localparam int unsigned LOCK_READ_BIT   = 1;
  localparam int unsigned ST_FBUSY_BIT    = 0;
  localparam int unsigned ST_EBUSY_BIT    = 1;
  localparam int unsigned ST_ERR_BIT      = 2;
  // ***********************************************************
  // op codes and states
  // ***********************************************************
  typedef enum logic [2:0] {
    OP_NONE               = 3'h0,
    OP_PAGE_PROGRAM       = 3'h1,
    PAGE_WIPE_OP          = 3'h2,
    PAGE_WIPE_AND_PROGRAM_OP = 3'h3,
    BUFFER_RESET_OP       = 3'h4,
    FULL_WIPE_OP          = 3'h5,
    NVDATA_WIPE_OP        = 3'h6,
    FUSE_PROGRAM_OP       = 3'h7
  } npc_op_type;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_WAIT  = 4'b1000
  } npc_state_type;
  typedef enum logic [1:0] {
    RGN_LOADER  = 2'h0,
    RGN_PROGRAM = 2'h1,
    RGN_STORAGE = 2'h2
  } npc_region_type;
endpackage : npc_pkg

// ==== hw/npc_region_map.sv ====
// flash region classification from end fuses
`timescale 1ns/10ps
`default_nettype none
module npc_region_map
  import npc_pkg::*;
#(
  parameter int unsigned AW = 16
)(
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    loader_end_fuse,
  input  wire logic [7:0]    program_region_end_fuse,
  output npc_region_type     region
);
  logic [7:0] blk;
  assign blk = addr[BLOCK_SHIFT +: 8];
  always_comb
  begin
    if (loader_end_fuse == FUSE_ZERO)
      region = RGN_LOADER; // RULE_02
    else if (blk < loader_end_fuse)
      region = RGN_LOADER; // RULE_01
    else if (program_region_end_fuse == FUSE_ZERO || blk < program_region_end_fuse)
      region = RGN_PROGRAM; // RULE_02
    else
      region = RGN_STORAGE;
  end
endmodule : npc_region_map
`default_nettype wire

// ==== test/npc_array_model.sv ====
// array side model: counts operations, flags unerased flash writes
`timescale 1ns/10ps
`default_nettype none
module npc_array_model
(
  input  wire logic        mclk,
  input  wire logic        arr_erase,
  input  wire logic        arr_write,
  input  wire logic        other_op,
  input  wire logic        arr_is_nvdata,
  input  wire logic [15:0] arr_page_addr,
  output logic [7:0]       n_es,
  output logic [7:0]       n_wr,
  output logic [7:0]       n_x,
  output logic             corrupt
);
  logic [15:0] es_page;
  logic        es_ok;
  initial
  begin
    n_es = 8'h00;
    n_wr = 8'h00;
    n_x = 8'h00;
    corrupt = 1'b0;
    es_ok = 1'b0;
    es_page = 16'h0000;
  end
  always @(posedge mclk)
  begin
    if (arr_erase)
    begin
      n_es <= n_es + 8'h01;
      es_page <= arr_page_addr;
      es_ok <= 1'b1;
    end
    if (arr_write)
    begin
      n_wr <= n_wr + 8'h01;
      if (!arr_is_nvdata && !(es_ok && es_page == arr_page_addr))
        corrupt <= 1'b1;
      if (!arr_is_nvdata)
        es_ok <= 1'b0;
    end
    if (other_op)
      n_x <= n_x + 8'h01;
  end
endmodule : npc_array_model
`default_nettype wire

// ==== test/npc_controller_bench.sv ====
// self-checking bench for the page program controller
`timescale 1ns/10ps
`default_nettype none
module npc_controller_bench
  import npc_pkg::*;
;
  typedef struct {logic [15:0] a, x; logic [2:0] op; int es, wr, ox, h;} npc_row_type;
  npc_row_type rows [12] = '{
    '{16'h1400, 16'h0000, 3'h1, 0, 1, 0, 0},
    '{16'h8100, 16'h0000, 3'h2, 1, 0, 0, 1},
    '{16'h8100, 16'h0000, 3'h3, 1, 1, 0, 1},
    '{16'h8200, 16'h0100, 3'h3, 1, 1, 0, 1},
    '{16'h8100, 16'h0100, 3'h3, 0, 0, 0, 0},
    '{16'h8200, 16'h0200, 3'h3, 0, 0, 0, 0},
    '{16'h8000, 16'h0000, 3'h3, 0, 0, 0, 0},
    '{16'h1300, 16'h0000, 3'h1, 0, 1, 0, 0},
    '{16'h1400, 16'h0000, 3'h2, 1, 0, 0, 0},
    '{16'h1400, 16'h0000, 3'h5, 0, 0, 1, 1},
    '{16'h1400, 16'h0000, 3'h6, 0, 0, 1, 1},
    '{16'h1400, 16'h0000, 3'h7, 0, 0, 0, 0}};
  logic mclk, rst_b, reg_wr, reg_rd, debug_programming_port, mem_wr, mem_rd, wake, keep_nvdata_fuse;
  logic mem_wait, cpu_halt, loader_hidden, arr_erase, arr_write, arr_chip_erase, arr_nvdata_erase;
  logic arr_keep_nvdata, arr_is_nvdata, fuse_write, corrupt;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mem_wdata, loader_end_fuse, program_region_end_fuse, s;
  logic [7:0] n_es, n_wr, n_x, b_es, b_wr, b_x;
  logic [15:0] mem_addr, exec_addr, arr_page_addr, fuse_addr, fuse_data, cap_d;
  logic [511:0] arr_data;
  logic [63:0] arr_mask;
  logic [1:0] cap_m;
  int errors, total_checks, cyc;
  npc_controller #(.SHORT_CYC(20), .LONG_CYC(40)) dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .debug_programming_port, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .exec_addr,
    .wake, .mem_wait, .cpu_halt, .loader_hidden, .loader_end_fuse, .program_region_end_fuse,
    .keep_nvdata_fuse, .arr_erase, .arr_write, .arr_chip_erase, .arr_nvdata_erase, .arr_keep_nvdata,
    .arr_is_nvdata, .arr_page_addr, .arr_data, .arr_mask, .fuse_write, .fuse_addr, .fuse_data);
  npc_array_model u_arr (.mclk, .arr_erase, .arr_write, .other_op(arr_chip_erase | arr_nvdata_erase | fuse_write),
    .arr_is_nvdata, .arr_page_addr, .n_es, .n_wr, .n_x, .corrupt);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (arr_write)
    begin
      cap_d <= arr_data[15:0];
      cap_m <= arr_mask[1:0];
    end
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      complete_run();
    end
  end
  // ****************
  // bus tasks
  // ****************
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
  task store(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge mclk);
    mem_wr <= 1'b0;
  endtask : store
  task cmd(input logic [2:0] op);
    wr(REG_GUARD, SELFPROG_UNLOCK_KEY);
    wr(REG_CONTROL_A, {5'h00, op});
  endtask : cmd
  task idle();
    s = 8'hff;
    for (int i = 0; i < 300 && (s[1:0] !== 2'h0 || cpu_halt !== 1'b0); i++)
      rd(REG_STATUS, s);
  endtask : idle
  task complete_run();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ****************
  // sequence
  // ****************
  initial
  begin
    {rst_b, reg_wr, reg_rd, debug_programming_port, mem_wr, mem_rd, wake} = 7'h00;
    {reg_addr, reg_wdata, mem_wdata, mem_addr, exec_addr} = 52'h0;
    loader_end_fuse = 8'h01;
    program_region_end_fuse = 8'h02;
    keep_nvdata_fuse = 1'b1;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(REG_STATUS, s);
    chk(s, 8'h00);
    chk(cpu_halt, 1'b0);
    foreach (rows[i])
    begin
      exec_addr <= rows[i].x;
      b_es = n_es;
      b_wr = n_wr;
      b_x = n_x;
      store(rows[i].a, 8'h5a);
      cmd(rows[i].op);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(cpu_halt, rows[i].h);
      idle();
      chk(n_es - b_es, rows[i].es);
      chk(n_wr - b_wr, rows[i].wr);
      chk(n_x - b_x, rows[i].ox);
    end
    $display("rows done");
    cmd(3'h4);
    idle();
    store(16'h1400, 8'hf0);
    store(16'h1400, 8'h3c);
    store(16'h1401, 8'ha5);
    cmd(3'h1);
    idle();
    chk(cap_d, 16'ha530);
    chk(cap_m, 2'h3);
    for (int m = 0; m < 3; m++)
    begin
      if (m != 0)
        store(16'h1400, 8'h00);
      if (m == 1)
        cmd(3'h4);
      if (m == 2)
      begin
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
      end
      idle();
      store(16'h1401, 8'h11);
      cmd(3'h1);
      idle();
      chk(cap_d, 16'h11ff);
      chk(cap_m, 2'h2);
    end
    $display("buffer done");
    b_es = n_es;
    b_wr = n_wr;
    cmd(3'h2);
    idle();
    chk(n_es - b_es, 0);
    store(16'h1400, 8'h12);
    wr(REG_GUARD, 8'h9c);
    wr(REG_CONTROL_A, 8'h01);
    wr(REG_CONTROL_A, 8'h01);
    idle();
    chk(n_wr - b_wr, 0);
    $display("refusal done");
    store(16'h8100, 8'h00);
    cmd(3'h2);
    mem_addr <= 16'h8100;
    mem_rd <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(mem_wait, 1'b1);
    idle();
    @(negedge mclk);
    chk(mem_wait, 1'b0);
    mem_rd <= 1'b0;
    $display("stall done");
    debug_programming_port <= 1'b1;
    wr(REG_ADDR_LO, 8'h34);
    wr(REG_ADDR_HI, 8'h12);
    wr(REG_DATA_LO, 8'hcd);
    wr(REG_DATA_HI, 8'hab);
    b_x = n_x;
    cmd(3'h7);
    idle();
    chk(n_x - b_x, 1);
    chk({fuse_addr, fuse_data}, 32'h1234_abcd);
    debug_programming_port <= 1'b0;
    $display("fuse done");
    wr(REG_CONTROL_B, 8'h03);
    exec_addr <= 16'h0100;
    @(negedge mclk);
    chk(loader_hidden, 1'b1);
    exec_addr <= 16'h0000;
    b_es = n_es;
    store(16'h8100, 8'h00);
    cmd(3'h3);
    idle();
    chk(n_es - b_es, 0);
    $display("lock done");
    store(16'h8200, 8'h00);
    cmd(3'h3);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b0;
    exec_addr <= 16'h0100;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    b_wr = n_wr;
    repeat (60) @(posedge mclk);
    @(negedge mclk);
    chk(n_wr - b_wr, 0);
    chk({cpu_halt, loader_hidden}, 2'h0);
    chk(corrupt, 1'b0);
    $display("reset done");
    complete_run();
  end
endmodule : npc_controller_bench
`default_nettype wire

// ==== test/npc_monitor.sv ====
// port assertions for the page program controller
`timescale 1ns/10ps
`default_nettype none
module npc_monitor
  import npc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       debug_programming_port,
  input wire logic       mem_rd,
  input wire logic       mem_wait,
  input wire logic       cpu_halt,
  input wire logic       keep_nvdata_fuse,
  input wire logic       arr_erase,
  input wire logic       arr_write,
  input wire logic       arr_chip_erase,
  input wire logic       arr_nvdata_erase,
  input wire logic       arr_keep_nvdata,
  input wire logic       arr_is_nvdata,
  input wire logic       fuse_write
);
  logic [2:0] key_cnt;
  wire logic  cmd_wr = reg_wr && reg_addr == REG_CONTROL_A;
  // key window: counts down four cycles
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      key_cnt <= 3'h0;
    else if (reg_wr && reg_addr == REG_GUARD && reg_wdata == SELFPROG_UNLOCK_KEY)
      key_cnt <= 3'h4;
    else if (key_cnt != 3'h0)
      key_cnt <= key_cnt - 3'h1;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  property p_clear_halt;
    cmd_wr && key_cnt != 3'h0 && reg_wdata[2:0] == 3'h4 && !cpu_halt |=> cpu_halt [*7] ##1 !cpu_halt;
  endproperty
  a_clear_halt: assert property (p_clear_halt) else $error("clear halt not seven cycles");
  property p_no_key;
    cmd_wr && key_cnt == 3'h0 && !debug_programming_port && !cpu_halt |=> !cpu_halt [*3];
  endproperty
  a_no_key: assert property (p_no_key) else $error("command ran without key");
  property p_fuse_cpu;
    cmd_wr && reg_wdata[2:0] == 3'h7 && !debug_programming_port |=> !fuse_write [*3];
  endproperty
  a_fuse_cpu: assert property (p_fuse_cpu) else $error("cpu started fuse write");
  property p_stall;
    mem_rd && $past(arr_erase) |-> mem_wait;
  endproperty
  a_stall: assert property (p_stall) else $error("read not stalled");
  property p_nv_run;
    arr_write && arr_is_nvdata |-> !cpu_halt;
  endproperty
  a_nv_run: assert property (p_nv_run) else $error("cpu halted on eeprom write");
  property p_fl_halt;
    (arr_erase || arr_write) && !arr_is_nvdata |-> cpu_halt ##1 cpu_halt;
  endproperty
  a_fl_halt: assert property (p_fl_halt) else $error("cpu runs during flash op");
  property p_keep;
    arr_chip_erase |-> arr_keep_nvdata == keep_nvdata_fuse;
  endproperty
  a_keep: assert property (p_keep) else $error("keep flag wrong");
  property p_wipe_halt;
    arr_chip_erase || arr_nvdata_erase |-> cpu_halt;
  endproperty
  a_wipe_halt: assert property (p_wipe_halt) else $error("cpu runs during wipe");
  property p_rst;
    $rose(rst_b) |-> !cpu_halt && !mem_wait;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
endmodule : npc_monitor
bind npc_controller npc_monitor u_mon (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .debug_programming_port, .mem_rd, .mem_wait, .cpu_halt, .keep_nvdata_fuse, .arr_erase,
  .arr_write, .arr_chip_erase, .arr_nvdata_erase, .arr_keep_nvdata, .arr_is_nvdata, .fuse_write);
`default_nettype wire
